// *** inc/port_mux_pkg.sv ***
`default_nettype none
package port_mux_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [1:0] R_DATA  = 2'h0;   // latch, or pin level when input
  localparam logic [1:0] R_DIR   = 2'h1;   // 1 = input, 0 = output
  localparam logic [1:0] R_PU    = 2'h2;   // pull-up enable per pin
  localparam logic [1:0] R_ALT   = 2'h3;   // 1 = control mode (peripheral)
  localparam logic [7:0] A_CFG   = 8'h80;  // misc pin options
  localparam logic [7:0] A_ANA   = 8'h84;  // port 2 analog select
  localparam logic [7:0] A_EDGE  = 8'h88;  // irq edge select, 2 bits each
  localparam logic [7:0] A_STAT  = 8'h8C;  // key and irq state, read only
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  DIR_RST  = 8'hFF;
  localparam logic [7:0]  ZERO8    = 8'h00;
  localparam logic [6:0]  CFG_RST  = 7'h00;
  localparam logic [15:0] EDGE_RST = 16'h0000;
  // ----------------------------------------
  // cfg fields
  // ----------------------------------------
  localparam int CFG_TTL43 = 0;  // port 4 bit 3 ttl input
  localparam int CFG_TTL44 = 1;  // port 4 bit 4 ttl input
  localparam int CFG_OD43  = 2;  // port 4 bit 3 open drain
  localparam int CFG_OD45  = 3;  // port 4 bit 5 open drain
  localparam int CFG_RAW   = 4;  // raw 32 kHz out
  localparam int CFG_DIV   = 5;  // divided 32 kHz out
  localparam int CFG_HZ    = 6;  // 1 Hz correction out
  // ----------------------------------------
  // pin placement
  // ----------------------------------------
  localparam int RTC_RAW_B = 4;  // port 1 bit
  localparam int RTC_DIV_B = 5;  // port 1 bit
  localparam int RTC_HZ_B  = 0;  // port 3 bit
  localparam logic [7:0] PU_MASK [1:7] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'hFF};
  localparam int IRQ_P [8] = '{1, 3, 3, 5, 7, 7, 7, 7};
  localparam int IRQ_B [8] = '{6, 0, 1, 0, 4, 5, 6, 7};
  localparam int TI_P [4] = '{1, 1, 3, 4};
  localparam int TI_B [4] = '{6, 7, 1, 2};
endpackage
`default_nettype wire

// *** hw/port_pin_function_mux.sv ***
// Contract
// - one direction bit per pin
// - pull-up on ports 1,3,4,5,7, not 2
// - port 6 pull-up only bits 4 to 7
// - port 6 bits 0-3 drive low only
// - port 4 bits 3,4 ttl input select
// - port 4 bits 3,5 open-drain select
// - port 2 digital input after reset
// - irq edge rising, falling or both
// - rtc raw and divided clock outputs
// - port 3 pin outputs 1 Hz tick
// - two-line debug takes port 4 bit 1
// - debug off keeps port 4 bit 0
// - port 7 key and irq inputs
// - timer pins feed count or capture
// - control mode chosen per pin
`default_nettype none
module port_pin_function_mux (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wbCyc,
  input  wire logic             wbStb,
  input  wire logic             wbWe,
  input  wire logic [7:0]       wbAdr,
  input  wire logic [31:0]      wbDatW,
  input  wire logic [3:0]       wbSel,
  output      logic [31:0]      wbDatR,
  output      logic             wbAck,
  input  wire logic [7:1][7:0]  pinIn,
  output      logic [7:1][7:0]  pinOut,
  output      logic [7:1][7:0]  pinOe,
  output      logic [7:1][7:0]  pinPullup,
  output      logic [1:0]       pinTtl,
  output      logic [7:0]       pinAnalog,
  input  wire logic [7:1][7:0]  periphOut,
  input  wire logic [7:1][7:0]  periphOe,
  input  wire logic             debuggerEnableFlag,
  input  wire logic             debugTwoLine,
  input  wire logic             debugDataOut,
  input  wire logic             debugDataOe,
  input  wire logic             debugClockOut,
  input  wire logic             rtcRawClockIn,
  input  wire logic             rtcDividedClockIn,
  input  wire logic             rtcCorrectionTickIn,
  output      logic [7:1][7:0]  pinSync,
  output      logic [7:0]       extIrqInput,
  output      logic [7:0]       keyIrqInputs,
  output      logic [3:0]       timerCountInput
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:1][7:0] data_r, data_nxt;   // output latches
  logic [7:1][7:0] dir_r, dir_nxt;     // direction, 1 = input
  logic [7:1][7:0] pu_r, pu_nxt;       // pull-up options
  logic [7:1][7:0] alt_r, alt_nxt;     // control mode select
  logic [6:0]      cfg_r, cfg_nxt;     // misc options
  logic [7:0]      ana_r, ana_nxt;     // port 2 analog select
  logic [15:0]     edge_r, edge_nxt;   // irq edge select
  logic            ack_r, ack_nxt;     // bus answer
  logic [31:0]     rdat_r, rdat_nxt;   // read data
  logic [7:1][7:0] meta_r, sync_r;     // pin synchroniser
  logic [7:1][7:0] prev_r;             // last synced level
  logic [2:0]      rtcMeta_r, rtcSync_r;
  logic [7:1][7:0] out_r, out_nxt;     // pin drive
  logic [7:1][7:0] oe_r, oe_nxt;       // pin enable
  logic [7:1][7:0] pull_r, pull_nxt;   // pull-up drive
  logic [7:0]      irq_r, irq_nxt;     // edge pulses
  logic [7:0]      key_r, key_nxt;     // key inputs
  logic [3:0]      ti_r, ti_nxt;       // timer inputs
  logic            hit;                // request not yet answered
  logic [2:0]      pIdx;               // port index from address
  logic            o, e;               // per-pin scratch
  logic            s, pv;              // irq scratch

  // ----------------------------------------
  // wishbone register file
  // ----------------------------------------
  // one-cycle ack; writes land with it, unmapped reads return zero
  always_comb begin
    data_nxt = data_r;
    dir_nxt = dir_r;
    pu_nxt = pu_r;
    alt_nxt = alt_r;
    cfg_nxt = cfg_r;
    ana_nxt = ana_r;
    edge_nxt = edge_r;
    hit = wbCyc & wbStb & ~ack_r;
    ack_nxt = hit;
    rdat_nxt = 32'h00000000;
    pIdx = wbAdr[6:4];
    if (hit && !wbAdr[7] && pIdx != 3'h0) begin
      unique case (wbAdr[3:2])
        port_mux_pkg::R_DATA: begin
          // input pins read the pin, output pins the latch
          rdat_nxt[7:0] = (dir_r[pIdx] & sync_r[pIdx]) | (~dir_r[pIdx] & data_r[pIdx]);
          if (wbWe && wbSel[0]) data_nxt[pIdx] = wbDatW[7:0];
        end
        port_mux_pkg::R_DIR: begin
          rdat_nxt[7:0] = dir_r[pIdx];
          if (wbWe && wbSel[0]) dir_nxt[pIdx] = wbDatW[7:0];
        end
        port_mux_pkg::R_PU: begin
          rdat_nxt[7:0] = pu_r[pIdx];
          if (wbWe && wbSel[0]) pu_nxt[pIdx] = wbDatW[7:0];
        end
        port_mux_pkg::R_ALT: begin
          rdat_nxt[7:0] = alt_r[pIdx];
          if (wbWe && wbSel[0]) alt_nxt[pIdx] = wbDatW[7:0];
        end
      endcase
    end else if (hit) begin
      unique case (wbAdr)
        port_mux_pkg::A_CFG: begin
          rdat_nxt[6:0] = cfg_r;
          if (wbWe && wbSel[0]) cfg_nxt = wbDatW[6:0];
        end
        port_mux_pkg::A_ANA: begin
          rdat_nxt[7:0] = ana_r;
          if (wbWe && wbSel[0]) ana_nxt = wbDatW[7:0];
        end
        port_mux_pkg::A_EDGE: begin
          rdat_nxt[15:0] = edge_r;
          if (wbWe && wbSel[0]) edge_nxt[7:0] = wbDatW[7:0];
          if (wbWe && wbSel[1]) edge_nxt[15:8] = wbDatW[15:8];
        end
        port_mux_pkg::A_STAT: rdat_nxt[17:0] = {debugTwoLine, debuggerEnableFlag, key_r, irq_r};
        default: rdat_nxt = 32'h00000000;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_r <= {7{port_mux_pkg::ZERO8}};
      dir_r <= {7{port_mux_pkg::DIR_RST}};
      pu_r <= {7{port_mux_pkg::ZERO8}};
      alt_r <= {7{port_mux_pkg::ZERO8}};
      cfg_r <= port_mux_pkg::CFG_RST;
      ana_r <= port_mux_pkg::ZERO8;
      edge_r <= port_mux_pkg::EDGE_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      pu_r <= pu_nxt;
      alt_r <= alt_nxt;
      cfg_r <= cfg_nxt;
      ana_r <= ana_nxt;
      edge_r <= edge_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // pins and rtc clocks come from outside this clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {7{port_mux_pkg::ZERO8}};
      sync_r <= {7{port_mux_pkg::ZERO8}};
      prev_r <= {7{port_mux_pkg::ZERO8}};
      rtcMeta_r <= 3'h0;
      rtcSync_r <= 3'h0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rtcMeta_r <= {rtcCorrectionTickIn, rtcDividedClockIn, rtcRawClockIn};
      rtcSync_r <= rtcMeta_r;
    end
  end

  // ----------------------------------------
  // pin multiplexer
  // ----------------------------------------
  always_comb begin
    o = 1'b0;
    e = 1'b0;
    out_nxt = {7{port_mux_pkg::ZERO8}};
    oe_nxt = {7{port_mux_pkg::ZERO8}};
    pull_nxt = {7{port_mux_pkg::ZERO8}};
    for (int p = 1; p <= 7; p++) begin
      for (int b = 0; b < 8; b++) begin
        // port mode: latch and direction
        o = data_r[p][b];
        e = ~dir_r[p][b];
        // control mode: peripheral drives the pin
        if (alt_r[p][b]) begin
          o = periphOut[p][b];
          e = periphOe[p][b];
        end
        // debug data pin only when debugging enabled
        if (p == 4 && b == 0 && debuggerEnableFlag) begin
          o = debugDataOut;
          e = debugDataOe;
        end
        // debug clock steals the pin in two-line mode
        if (p == 4 && b == 1 && debuggerEnableFlag && debugTwoLine) begin
          o = debugClockOut;
          e = 1'b1;
        end
        // raw clock wins if software enables both
        if (p == 1 && b == port_mux_pkg::RTC_RAW_B && cfg_r[port_mux_pkg::CFG_RAW]) begin
          o = rtcSync_r[0];
          e = 1'b1;
        end
        if (p == 1 && b == port_mux_pkg::RTC_DIV_B && cfg_r[port_mux_pkg::CFG_DIV]
            && !cfg_r[port_mux_pkg::CFG_RAW]) begin
          o = rtcSync_r[1];
          e = 1'b1;
        end
        if (p == 3 && b == port_mux_pkg::RTC_HZ_B && cfg_r[port_mux_pkg::CFG_HZ]) begin
          o = rtcSync_r[2];
          e = 1'b1;
        end
        // open drain: drive low, release for high
        if ((p == 6 && b < 4)
            || (p == 4 && b == 3 && cfg_r[port_mux_pkg::CFG_OD43])
            || (p == 4 && b == 5 && cfg_r[port_mux_pkg::CFG_OD45])) begin
          e = e & ~o;
          o = 1'b0;
        end
        // analog pins never drive
        if (p == 2 && ana_r[b]) e = 1'b0;
        out_nxt[p][b] = o;
        oe_nxt[p][b] = e;
        // pull-up only on input pins that have one
        pull_nxt[p][b] = pu_r[p][b] & dir_r[p][b] & port_mux_pkg::PU_MASK[p][b];
      end
    end
  end

  // ----------------------------------------
  // peripheral inputs
  // ----------------------------------------
  always_comb begin
    s = 1'b0;
    pv = 1'b0;
    irq_nxt = 8'h00;
    key_nxt = 8'h00;
    ti_nxt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      s = sync_r[port_mux_pkg::IRQ_P[i]][port_mux_pkg::IRQ_B[i]];
      pv = prev_r[port_mux_pkg::IRQ_P[i]][port_mux_pkg::IRQ_B[i]];
      // bit 0 rising, bit 1 falling, both for either
      irq_nxt[i] = alt_r[port_mux_pkg::IRQ_P[i]][port_mux_pkg::IRQ_B[i]]
                   & ((edge_r[2*i] & s & ~pv) | (edge_r[2*i+1] & ~s & pv));
      // key inputs idle high outside control mode
      key_nxt[i] = alt_r[7][i] ? sync_r[7][i] : 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      ti_nxt[i] = alt_r[port_mux_pkg::TI_P[i]][port_mux_pkg::TI_B[i]]
                  & sync_r[port_mux_pkg::TI_P[i]][port_mux_pkg::TI_B[i]];
    end
  end

  // output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_r <= {7{port_mux_pkg::ZERO8}};
      oe_r <= {7{port_mux_pkg::ZERO8}};
      pull_r <= {7{port_mux_pkg::ZERO8}};
      irq_r <= 8'h00;
      key_r <= 8'hFF;
      ti_r <= 4'h0;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pull_r <= pull_nxt;
      irq_r <= irq_nxt;
      key_r <= key_nxt;
      ti_r <= ti_nxt;
    end
  end

  assign wbDatR = rdat_r;
  assign wbAck = ack_r;
  assign pinOut = out_r;
  assign pinOe = oe_r;
  assign pinPullup = pull_r;
  assign pinTtl = cfg_r[port_mux_pkg::CFG_TTL44:port_mux_pkg::CFG_TTL43];
  assign pinAnalog = ana_r;
  assign pinSync = sync_r;
  assign extIrqInput = irq_r;
  assign keyIrqInputs = key_r;
  assign timerCountInput = ti_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ack_single_a: assert property (ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");
  dir_drive_a: assert property (!alt_r[5][0] |=> pinOe[5][0] == !$past(dir_r[5][0]))
    else $error("port 5 enable does not follow direction");
  pullup_mask_a: assert property (pinPullup[2] == 8'h00 && pinPullup[6][3:0] == 4'h0)
    else $error("pull-up on pin without option");
  p6_lowonly_a: assert property (pinOut[6][3:0] == 4'h0)
    else $error("port 6 low pins drive high");
  ttl_select_a: assert property (pinTtl == {cfg_r[port_mux_pkg::CFG_TTL44], cfg_r[port_mux_pkg::CFG_TTL43]})
    else $error("ttl select mismatch");
  od_p45_a: assert property (cfg_r[3] |=> !pinOut[4][5])
    else $error("open-drain pin drives high");
  analog_rst_a: assert property (@(posedge clk) disable iff (1'b0) !nrst |-> ana_r == 8'h00)
    else $error("port 2 not digital in reset");
  edge_rise_a: assert property (alt_r[7][4] && edge_r[8] && sync_r[7][4] && !prev_r[7][4]
    |=> extIrqInput[4])
    else $error("rising edge missed");
  dbg_clock_a: assert property (debuggerEnableFlag && debugTwoLine |=> pinOe[4][1])
    else $error("debug clock not driven");
  dbg_off_a: assert property (!debuggerEnableFlag && !alt_r[4][0]
    |=> pinOe[4][0] == !$past(dir_r[4][0]))
    else $error("port 4 bit 0 not a port");
  rtc_raw_a: assert property (cfg_r[4] |=> pinOe[1][4] && pinOut[1][4] == $past(rtcSync_r[0]))
    else $error("raw rtc clock not on pin");
  timer_in_a: assert property (alt_r[3][1] |=> timerCountInput[2] == $past(sync_r[3][1]))
    else $error("timer input not passed");

  wb_write_c: cover property (wbCyc && wbStb && wbWe ##1 wbAck);
  irq_fire_c: cover property (extIrqInput != 8'h00);
  dbg_two_c: cover property (debuggerEnableFlag && debugTwoLine);
endmodule
`default_nettype wire

// *** sim/pin_board_model.sv ***
`default_nettype none
module pin_board_model (
  input  wire logic             clk,
  input  wire logic [7:1][7:0]  pinOut,
  input  wire logic [7:1][7:0]  pinOe,
  input  wire logic [7:1][7:0]  pinPullup,
  input  wire logic [7:1][7:0]  extDrv,
  input  wire logic [7:1][7:0]  extVal,
  input  wire logic             dbgEn,
  output      logic [7:1][7:0]  pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // board side of the pins
  // ------------------------------
  logic [7:1][7:0] flt;   // undriven lines wander every cycle
  logic [7:1][7:0] pull;  // on-chip and board pull-ups
  initial flt = '0;
  // a floating line never holds its last level
  always @(posedge clk) begin
    flt <= ~flt;
  end
  // board resistor on the debug data pin while debugging is on
  always_comb begin
    pull = pinPullup;
    pull[4][0] = pinPullup[4][0] | dbgEn;
  end
  // device drive wins, then board drive, then pulls, else wander
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extVal) | (~pinOe & ~extDrv & (pull | flt));
endmodule
`default_nettype wire

// *** sim/tb_port_pin_function_mux.sv ***
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_port_pin_function_mux;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  logic             clk, nrst, wbCyc, wbStb, wbWe, wbAck, debuggerEnableFlag, debugTwoLine;
  logic             debugDataOe, debugClockOut, rtcRawClockIn, rtcDividedClockIn, rtcCorrectionTickIn;
  logic [7:0]       wbAdr, pinAnalog, extIrqInput, keyIrqInputs;
  logic [31:0]      wbDatW, wbDatR, rdData;
  logic [1:0]       pinTtl;
  logic [3:0]       timerCountInput;
  logic [7:1][7:0]  pinIn, pinOut, pinOe, pinPullup, periphOut, periphOe, pinSync, extDrv, extVal;
  int               failures, n_tests;
  port_pin_function_mux DUT (
    .clk, .nrst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatW, .wbSel(4'hF), .wbDatR, .wbAck,
    .pinIn, .pinOut, .pinOe, .pinPullup, .pinTtl, .pinAnalog, .periphOut, .periphOe,
    .debuggerEnableFlag, .debugTwoLine, .debugDataOut(1'b0), .debugDataOe, .debugClockOut,
    .rtcRawClockIn, .rtcDividedClockIn, .rtcCorrectionTickIn, .pinSync, .extIrqInput,
    .keyIrqInputs, .timerCountInput
  );
  pin_board_model board (
    .clk, .pinOut, .pinOe, .pinPullup, .extDrv, .extVal, .dbgEn(debuggerEnableFlag), .pinIn
  );
  // 50 MHz clock
  always #10 clk = ~clk;
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic bus cycle, ack awaited at most 20 edges
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      final_report();
    end else begin
      rdData = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
    end
  endtask
  // let n edges pass, then look just after the last one
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // move the driven irq and timer lines, count irq pulses
  task automatic pulse(input logic v, output int n);
    @(posedge clk);
    extVal[7][4] <= v;
    extVal[1][6] <= v;
    n = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (extIrqInput[4] === 1'b1) n++;
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic s_reset();
    settle(1);
    `CHK(pinOe, 56'h0)
    `CHK(pinAnalog, 8'h00)
    xfer(1'b0, 8'h24, 32'h0);
    `CHK(rdData, 32'h0000_00FF)
    xfer(1'b0, 8'h84, 32'h0);
    `CHK(rdData, 32'h0000_0000)
    xfer(1'b0, 8'hFC, 32'h0);
    `CHK(rdData, 32'h0000_0000)
  endtask
  task automatic s_dir();
    xfer(1'b1, 8'h50, 32'h01);
    xfer(1'b1, 8'h54, 32'hFE);
    // control mode left off, so port 1 bits 0 and 2 are plain ports
    xfer(1'b1, 8'h14, 32'hFA);
    settle(2);
    `CHK(pinOe[5], 8'h01)
    `CHK(pinOut[5][0], 1'b1)
    `CHK(pinOe[1], 8'h05)
    xfer(1'b1, 8'h54, 32'hFF);
    xfer(1'b1, 8'h14, 32'hFF);
  endtask
  task automatic s_pull();
    for (logic [3:0] p = 4'h1; p < 4'h8; p++) xfer(1'b1, {p, 4'h8}, 32'hFF);
    settle(2);
    `CHK(pinPullup, 56'hFF_F0_FF_FF_FF_00_FF)
  endtask
  task automatic s_od6();
    xfer(1'b1, 8'h60, 32'h05);
    xfer(1'b1, 8'h64, 32'h00);
    xfer(1'b1, 8'h84, 32'h0F);
    xfer(1'b1, 8'h24, 32'h00);
    settle(2);
    `CHK(pinOe[6], 8'hFA)
    `CHK(pinOut[6], 8'h00)
    `CHK({pinAnalog, pinOe[2]}, 16'h0FF0)
    xfer(1'b1, 8'h64, 32'hFF);
    xfer(1'b1, 8'h84, 32'h00);
    xfer(1'b1, 8'h24, 32'hFF);
  endtask
  task automatic s_cfg();
    xfer(1'b1, 8'h80, 32'h0F);
    xfer(1'b1, 8'h40, 32'h29);
    xfer(1'b1, 8'h44, 32'h00);
    settle(2);
    `CHK(pinTtl, 2'b11)
    `CHK(pinOe[4], 8'hD7)
    `CHK(pinOut[4], 8'h01)
    @(posedge clk);
    debuggerEnableFlag <= 1'b1;
    settle(3);
    `CHK(pinOe[4][1:0], 2'b10)
    @(posedge clk);
    debugTwoLine <= 1'b1;
    debugClockOut <= 1'b1;
    settle(3);
    `CHK({pinOe[4][1], pinOut[4][1]}, 2'b11)
    xfer(1'b0, 8'h8C, 32'h0);
    `CHK(rdData, 32'h0003_FF00)
    @(posedge clk);
    debuggerEnableFlag <= 1'b0;
    debugTwoLine <= 1'b0;
    xfer(1'b1, 8'h80, 32'h00);
    xfer(1'b1, 8'h44, 32'hFF);
  endtask
  task automatic s_rtc();
    @(posedge clk);
    rtcRawClockIn <= 1'b1;
    rtcDividedClockIn <= 1'b1;
    rtcCorrectionTickIn <= 1'b1;
    xfer(1'b1, 8'h80, 32'h50);
    settle(4);
    `CHK({pinOe[1][5:4], pinOut[1][4]}, 3'b011)
    `CHK({pinOe[3][0], pinOut[3][0]}, 2'b11)
    @(posedge clk);
    rtcRawClockIn <= 1'b0;
    settle(4);
    `CHK(pinOut[1][4], 1'b0)
    xfer(1'b1, 8'h80, 32'h20);
    settle(4);
    `CHK({pinOe[1][5:4], pinOut[1][5]}, 3'b101)
    xfer(1'b1, 8'h80, 32'h00);
  endtask
  task automatic s_alt();
    @(posedge clk);
    periphOe[5] <= 8'hFF;
    periphOut[5] <= 8'hA4;
    xfer(1'b1, 8'h5C, 32'h0F);
    settle(2);
    `CHK(pinOe[5], 8'h0F)
    `CHK(pinOut[5], 8'h04)
    xfer(1'b1, 8'h5C, 32'h00);
    periphOe[5] <= 8'h00;
  endtask
  task automatic s_irq();
    int n;
    xfer(1'b1, 8'h7C, 32'hFF);
    xfer(1'b1, 8'h1C, 32'hC0);
    extDrv[7][4] <= 1'b1;
    extDrv[1][6] <= 1'b1;
    for (logic [1:0] m = 2'h1; m != 2'h0; m++) begin
      xfer(1'b1, 8'h88, {22'h0, m, 8'h00});
      settle(6);
      pulse(1'b1, n);
      `CHK(n, int'(m[0]))
      `CHK({keyIrqInputs[4], timerCountInput[0], pinSync[7][4]}, 3'b111)
      pulse(1'b0, n);
      `CHK(n, int'(m[1]))
      `CHK({keyIrqInputs[4], timerCountInput[0], pinSync[7][4]}, 3'b000)
    end
    // input pins read back their level: only the driven low pin is 0
    xfer(1'b0, 8'h70, 32'h0);
    `CHK(rdData, 32'h0000_00EF)
  endtask
  // reset, then every scenario in turn
  initial begin
    clk = 1'b0;
    nrst = 1'b1;
    {wbCyc, wbStb, wbWe, debuggerEnableFlag, debugTwoLine, debugDataOe, debugClockOut} = '0;
    {rtcRawClockIn, rtcDividedClockIn, rtcCorrectionTickIn} = '0;
    wbAdr = 8'h00;
    wbDatW = 32'h0;
    {periphOut, periphOe, extDrv, extVal} = '0;
    failures = 0;
    n_tests = 0;
    // a clean falling edge so the async reset acts before the first clock edge
    #2 nrst = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    s_reset();
    s_dir();
    s_pull();
    s_od6();
    s_cfg();
    s_rtc();
    s_alt();
    s_irq();
    final_report();
  end
endmodule
`default_nettype wire
